// >>> verification/mrd_core_tb.sv
// Self-checking testbench for the opcode decode and execute block.
`timescale 1ns/1ps
module mrd_core_tb;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [13:0] opcode = 14'h0_000;
   logic [10:0] stack_top_entry = 11'h000;
   logic [7:0] file_rdata = 8'h00;
   logic [7:0] accumulator;
   logic [10:0] program_counter;
   logic [7:0] interrupt_control_register;
   logic [7:0] timer_config;
   logic stack_pop;
   logic file_we;
   logic [6:0] file_waddr;
   logic [7:0] file_wdata;
   logic [6:0] file_raddr;
   logic [7:0] file_rd_data;
   logic fetch_flush;
   int bad_count = 0;
   int check_count = 0;
   logic [10:0] prog_seen;

   always #5 sys_clk = ~sys_clk;

   mrd_core DUT (.sys_clk(sys_clk), .rst_n(rst_n), .opcode(opcode),
      .stack_top_entry(stack_top_entry), .file_rdata(file_rdata), .accumulator(accumulator),
      .program_counter(program_counter), .interrupt_control_register(interrupt_control_register),
      .timer_config(timer_config), .stack_pop(stack_pop), .file_we(file_we),
      .file_waddr(file_waddr), .file_wdata(file_wdata), .file_raddr(file_raddr),
      .file_rd_data(file_rd_data), .fetch_flush(fetch_flush));

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // One opcode is presented for exactly one sampling edge, then the idle opcode follows.
   task automatic run(input logic [13:0] op);
      @(posedge sys_clk);
      opcode <= op;
      @(posedge sys_clk);
      opcode <= 14'h0_000;
      #1;
   endtask

   task automatic t_reset();
      chk("acc", 16'h0000, accumulator);
      chk("prog_count", 16'h0000, program_counter);
      chk("intctl", 16'h0000, interrupt_control_register);
      chk("timer", 16'h00ff, timer_config);
      chk("pulses", 16'h0000, {stack_pop, file_we, fetch_flush});
   endtask

   task automatic t_literal();
      logic [7:0] k;
      for (int i = 0; i < 4; i++) begin
         k = 8'h5a ^ 8'(i * 37);
         prog_seen = program_counter;
         // The two don't-care bits step through all four values.
         run({4'hc, 2'(i), k});
         chk("acc", 16'(k), accumulator);
         chk("prog_count", 16'(prog_seen + 11'h002), program_counter);
         chk("intctl", 16'h0000, interrupt_control_register);
      end
   endtask

   // A store right behind a literal load must see the fresh accumulator value.
   task automatic t_store();
      @(posedge sys_clk);
      opcode <= 14'h3_0c9;
      @(posedge sys_clk);
      opcode <= 14'h0_0ff;
      @(posedge sys_clk);
      opcode <= 14'h0_000;
      #1;
      chk("we", 16'h0001, file_we);
      chk("waddr", 16'h007f, file_waddr);
      chk("wdata", 16'h00c9, file_wdata);
      @(posedge sys_clk);
      #1;
      chk("we_pulse", 16'h0000, file_we);
      run(14'h0_080);
      chk("waddr0", 16'h0000, file_waddr);
      chk("timer", 16'h00ff, timer_config);
   endtask

   task automatic t_timer_file();
      run(14'h3_0e7);
      run(14'h0_081);
      chk("timer", 16'h00e7, timer_config);
      chk("we", 16'h0000, file_we);
      run(14'h0_801);
      chk("raddr", 16'h0001, file_raddr);
      chk("rd_timer", 16'h00e7, file_rd_data);
      @(posedge sys_clk);
      file_rdata <= 8'h96;
      opcode <= 14'h0_822;
      @(posedge sys_clk);
      opcode <= 14'h0_000;
      #1;
      chk("rd_file", 16'h0096, file_rd_data);
   endtask

   task automatic t_timer_op();
      run(14'h3_03c);
      run(14'h0_062);
      chk("timer", 16'h003c, timer_config);
      chk("acc", 16'h003c, accumulator);
      chk("we", 16'h0000, file_we);
   endtask

   task automatic t_idle();
      prog_seen = program_counter;
      run(14'h0_060);
      chk("prog_count", 16'(prog_seen + 11'h002), program_counter);
      chk("acc", 16'h003c, accumulator);
      chk("timer", 16'h003c, timer_config);
      chk("we", 16'h0000, file_we);
   endtask

   // A literal load placed in the flush cycle must be discarded.
   task automatic t_return();
      @(posedge sys_clk);
      stack_top_entry <= 11'h5a3;
      opcode <= 14'h0_009;
      @(posedge sys_clk);
      opcode <= 14'h3_0ff;
      #1;
      chk("prog_count", 16'h05a3, program_counter);
      chk("pop", 16'h0001, stack_pop);
      chk("global_en", 16'h0080, interrupt_control_register);
      chk("flush", 16'h0001, fetch_flush);
      @(posedge sys_clk);
      opcode <= 14'h0_000;
      #1;
      chk("prog_hold", 16'h05a3, program_counter);
      chk("acc", 16'h003c, accumulator);
      chk("pulses", 16'h0000, {stack_pop, fetch_flush});
      @(posedge sys_clk);
      #1;
      chk("prog_next", 16'h05a4, program_counter);
   endtask

   initial begin
      repeat (3) @(posedge sys_clk);
      #1;
      t_reset();
      @(posedge sys_clk);
      rst_n <= 1'b1;
      t_literal();
      t_store();
      t_timer_file();
      t_timer_op();
      t_idle();
      t_return();
      print_verdict();
   end

   // The sequence needs well under 100 cycles; this span leaves a wide margin.
   initial begin
      #20000;
      bad_count++;
      print_verdict();
   end
endmodule

// >>> verilog/mrd_core.sv
// Execute stage for literal load, store, idle, interrupt return and timer load.
// Function
// - Literal load puts low byte in accumulator.
// - Store copies accumulator to addressed file register.
// - Interrupt return pops stack into program counter.
// - Interrupt return sets global enable, flags untouched.
// - Interrupt return takes two instruction cycles.
// - Timer load copies accumulator to timer configuration.
// - Timer configuration also reachable by file addressing.
`timescale 1ns/1ps
module mrd_core (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [13:0] opcode,
   input wire logic [10:0] stack_top_entry,
   input wire logic [7:0] file_rdata,
   output logic [7:0] accumulator,
   output logic [10:0] program_counter,
   output logic [7:0] interrupt_control_register,
   output logic [7:0] timer_config,
   output logic stack_pop,
   output logic file_we,
   output logic [6:0] file_waddr,
   output logic [7:0] file_wdata,
   output logic [6:0] file_raddr,
   output logic [7:0] file_rd_data,
   output logic fetch_flush
);
   mrd_dec_if dec_bus ();
   mrd_pkg::mrd_state_e state;
   mrd_pkg::mrd_state_e next_state;
   logic [7:0] next_accumulator;
   logic [10:0] next_program_counter;
   logic [7:0] next_interrupt_control_register;
   logic [7:0] next_timer_config;
   logic next_stack_pop;
   logic next_file_we;
   logic [6:0] next_file_waddr;
   logic [7:0] next_file_wdata;
   logic [6:0] next_file_raddr;
   logic [7:0] next_file_rd_data;
   logic next_fetch_flush;

   mrd_decoder u_decoder (
      .opcode(opcode),
      .dec(dec_bus.dec)
   );

   always_comb begin
      next_state = mrd_pkg::MRD_ST_RUN;
      next_accumulator = accumulator;
      next_program_counter = program_counter + 11'h001;
      next_interrupt_control_register = interrupt_control_register;
      next_timer_config = timer_config;
      next_stack_pop = 1'b0;
      next_file_we = 1'b0;
      next_file_waddr = file_waddr;
      next_file_wdata = file_wdata;
      next_file_raddr = dec_bus.faddr;
      // Reads of the timer configuration address are served locally.
      next_file_rd_data = (dec_bus.faddr == mrd_pkg::TCFG_ADDR) ? timer_config : file_rdata;
      next_fetch_flush = 1'b0;
      if (state == mrd_pkg::MRD_ST_FLUSH) begin
         // Second cycle of the return: the prefetched word is discarded.
         next_program_counter = program_counter;
      end else begin
         case (dec_bus.op)
            mrd_pkg::MRD_OP_LIT: begin
               next_accumulator = dec_bus.literal;
            end
            mrd_pkg::MRD_OP_STORE: begin
               if (dec_bus.faddr == mrd_pkg::TCFG_ADDR) begin
                  next_timer_config = accumulator;
               end else begin
                  next_file_we = 1'b1;
                  next_file_waddr = dec_bus.faddr;
                  next_file_wdata = accumulator;
               end
            end
            mrd_pkg::MRD_OP_RETI: begin
               next_program_counter = stack_top_entry;
               next_stack_pop = 1'b1;
               next_interrupt_control_register[mrd_pkg::INT_ENABLE_BIT] = 1'b1;
               next_state = mrd_pkg::MRD_ST_FLUSH;
               next_fetch_flush = 1'b1;
            end
            mrd_pkg::MRD_OP_TCFG: begin
               next_timer_config = accumulator;
            end
            mrd_pkg::MRD_OP_IDLE: begin
               next_accumulator = accumulator;
            end
            default: begin
               next_accumulator = accumulator;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= mrd_pkg::MRD_ST_RUN;
         accumulator <= mrd_pkg::ACC_RESET;
         program_counter <= mrd_pkg::PROG_COUNT_RESET;
         interrupt_control_register <= mrd_pkg::INTCTL_RESET;
         timer_config <= mrd_pkg::TCFG_RESET;
         stack_pop <= 1'b0;
         file_we <= 1'b0;
         file_waddr <= 7'h00;
         file_wdata <= 8'h00;
         file_raddr <= 7'h00;
         file_rd_data <= 8'h00;
         fetch_flush <= 1'b0;
      end else begin
         state <= next_state;
         accumulator <= next_accumulator;
         program_counter <= next_program_counter;
         interrupt_control_register <= next_interrupt_control_register;
         timer_config <= next_timer_config;
         stack_pop <= next_stack_pop;
         file_we <= next_file_we;
         file_waddr <= next_file_waddr;
         file_wdata <= next_file_wdata;
         file_raddr <= next_file_raddr;
         file_rd_data <= next_file_rd_data;
         fetch_flush <= next_fetch_flush;
      end
   end

   // Every antecedent also asks for the sampled reset to be high. On the edge that releases
   // reset the registers still sit at their reset values, so nothing was executed there and
   // a check that compared against the previous cycle would fire for no reason.
   property p_lit;
      @(posedge sys_clk) disable iff (!rst_n)
      (rst_n && state == mrd_pkg::MRD_ST_RUN && dec_bus.op == mrd_pkg::MRD_OP_LIT)
         |=> accumulator == $past(opcode[7:0]);
   endproperty
   a_lit: assert property (p_lit) else $error("literal not loaded");

   property p_store;
      @(posedge sys_clk) disable iff (!rst_n)
      (rst_n && state == mrd_pkg::MRD_ST_RUN && dec_bus.op == mrd_pkg::MRD_OP_STORE
         && dec_bus.faddr != mrd_pkg::TCFG_ADDR)
         |=> file_we && file_wdata == $past(accumulator) && file_waddr == $past(opcode[6:0]);
   endproperty
   a_store: assert property (p_store) else $error("store write wrong");

   property p_reti_jump;
      @(posedge sys_clk) disable iff (!rst_n)
      (rst_n && state == mrd_pkg::MRD_ST_RUN && dec_bus.op == mrd_pkg::MRD_OP_RETI)
         |=> stack_pop && program_counter == $past(stack_top_entry);
   endproperty
   a_reti_jump: assert property (p_reti_jump) else $error("return address not loaded");

   property p_reti_enable;
      @(posedge sys_clk) disable iff (!rst_n)
      (rst_n && state == mrd_pkg::MRD_ST_RUN && dec_bus.op == mrd_pkg::MRD_OP_RETI)
         |=> interrupt_control_register[mrd_pkg::INT_ENABLE_BIT]
            && accumulator == $past(accumulator);
   endproperty
   a_reti_enable: assert property (p_reti_enable) else $error("global enable not set");

   // Only the return may touch the interrupt control register; a stray write would
   // re-enable or mask interrupts behind the software's back.
   property p_enable_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      (rst_n && !(state == mrd_pkg::MRD_ST_RUN && dec_bus.op == mrd_pkg::MRD_OP_RETI))
         |=> $stable(interrupt_control_register);
   endproperty
   a_enable_hold: assert property (p_enable_hold) else $error("interrupt control changed");

   property p_reti_two;
      @(posedge sys_clk) disable iff (!rst_n)
      (rst_n && state == mrd_pkg::MRD_ST_RUN && dec_bus.op == mrd_pkg::MRD_OP_RETI)
         |=> state == mrd_pkg::MRD_ST_FLUSH ##1 state == mrd_pkg::MRD_ST_RUN
            && $stable(program_counter);
   endproperty
   a_reti_two: assert property (p_reti_two) else $error("return not two cycles");

   property p_reti_once;
      @(posedge sys_clk) disable iff (!rst_n)
      (rst_n && stack_pop)
         |-> fetch_flush && state == mrd_pkg::MRD_ST_FLUSH ##1 !stack_pop && !fetch_flush;
   endproperty
   a_reti_once: assert property (p_reti_once) else $error("return pulses wrong");

   // The word fetched behind a return is discarded, whatever it decodes to.
   property p_flush_quiet;
      @(posedge sys_clk) disable iff (!rst_n)
      (rst_n && state == mrd_pkg::MRD_ST_FLUSH)
         |=> $stable(accumulator) && $stable(program_counter) && $stable(timer_config)
            && !file_we && !stack_pop && !fetch_flush;
   endproperty
   a_flush_quiet: assert property (p_flush_quiet) else $error("flush cycle executed");

   property p_tcfg;
      @(posedge sys_clk) disable iff (!rst_n)
      (rst_n && state == mrd_pkg::MRD_ST_RUN && dec_bus.op == mrd_pkg::MRD_OP_TCFG)
         |=> timer_config == $past(accumulator) && !file_we;
   endproperty
   a_tcfg: assert property (p_tcfg) else $error("timer load wrong");

   property p_tcfg_file;
      @(posedge sys_clk) disable iff (!rst_n)
      (rst_n && state == mrd_pkg::MRD_ST_RUN && dec_bus.op == mrd_pkg::MRD_OP_STORE
         && dec_bus.faddr == mrd_pkg::TCFG_ADDR)
         |=> timer_config == $past(accumulator) && !file_we;
   endproperty
   a_tcfg_file: assert property (p_tcfg_file) else $error("timer file write wrong");

   property p_idle;
      @(posedge sys_clk) disable iff (!rst_n)
      (rst_n && state == mrd_pkg::MRD_ST_RUN && dec_bus.op == mrd_pkg::MRD_OP_IDLE)
         |=> $stable(accumulator) && $stable(timer_config) && !file_we && !stack_pop
            && program_counter == $past(program_counter) + 11'h001;
   endproperty
   a_idle: assert property (p_idle) else $error("idle changed state");

   c_reti: cover property (@(posedge sys_clk) disable iff (!rst_n)
      dec_bus.op == mrd_pkg::MRD_OP_RETI ##1 dec_bus.op == mrd_pkg::MRD_OP_LIT);
   c_store: cover property (@(posedge sys_clk) disable iff (!rst_n) file_we);
   c_tcfg: cover property (@(posedge sys_clk) disable iff (!rst_n)
      dec_bus.op == mrd_pkg::MRD_OP_TCFG);
   c_idle: cover property (@(posedge sys_clk) disable iff (!rst_n)
      state == mrd_pkg::MRD_ST_RUN && dec_bus.op == mrd_pkg::MRD_OP_IDLE);
endmodule

// >>> verilog/mrd_dec_if.sv
// Interface carrying the decoded instruction from decoder to executer.
`timescale 1ns/1ps
interface mrd_dec_if;
   mrd_pkg::mrd_op_e op;
   logic [7:0] literal;
   logic [6:0] faddr;
   modport dec (output op, output literal, output faddr);
   modport exe (input op, input literal, input faddr);
endinterface

// >>> verilog/mrd_decoder.sv
// Combinational opcode classifier for the five handled instructions.
`timescale 1ns/1ps
module mrd_decoder (
   input wire logic [13:0] opcode,
   mrd_dec_if.dec dec
);
   always_comb begin
      dec.literal = opcode[7:0];
      dec.faddr = opcode[6:0];
      if ((opcode & mrd_pkg::LIT_MASK) == mrd_pkg::LIT_PAT) begin
         dec.op = mrd_pkg::MRD_OP_LIT;
      end else if ((opcode & mrd_pkg::STORE_MASK) == mrd_pkg::STORE_PAT) begin
         dec.op = mrd_pkg::MRD_OP_STORE;
      end else if (opcode == mrd_pkg::RETI_PAT) begin
         dec.op = mrd_pkg::MRD_OP_RETI;
      end else if (opcode == mrd_pkg::TCFG_PAT) begin
         dec.op = mrd_pkg::MRD_OP_TCFG;
      end else if ((opcode & mrd_pkg::IDLE_MASK) == mrd_pkg::IDLE_PAT) begin
         dec.op = mrd_pkg::MRD_OP_IDLE;
      end else begin
         dec.op = mrd_pkg::MRD_OP_OTHER;
      end
   end
endmodule

// >>> verilog/mrd_pkg.sv
// Shared constants and types for the opcode decode and execute block.
package mrd_pkg;
   localparam int unsigned OP_W = 14;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 7;
   localparam int unsigned PROG_COUNT_W = 11;
   // Opcode patterns and masks.
   localparam logic [13:0] LIT_MASK = 14'h3_c00;
   localparam logic [13:0] LIT_PAT = 14'h3_000;
   localparam logic [13:0] STORE_MASK = 14'h3_f80;
   localparam logic [13:0] STORE_PAT = 14'h0_080;
   localparam logic [13:0] RETI_PAT = 14'h0_009;
   localparam logic [13:0] TCFG_PAT = 14'h0_062;
   localparam logic [13:0] IDLE_MASK = 14'h3_f9f;
   localparam logic [13:0] IDLE_PAT = 14'h0_000;
   // Interrupt control register layout.
   localparam int unsigned INT_ENABLE_BIT = 7;
   localparam logic [7:0] INTCTL_RESET = 8'h00;
   // File address of the timer configuration register.
   localparam logic [6:0] TCFG_ADDR = 7'h01;
   localparam logic [7:0] TCFG_RESET = 8'hff;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [10:0] PROG_COUNT_RESET = 11'h000;
   localparam logic [1:0] RETI_CYCLES = 2'h2;
   typedef enum logic [2:0] {
      MRD_OP_OTHER = 3'b000,
      MRD_OP_LIT = 3'b001,
      MRD_OP_STORE = 3'b010,
      MRD_OP_IDLE = 3'b011,
      MRD_OP_RETI = 3'b100,
      MRD_OP_TCFG = 3'b101
   } mrd_op_e;
   typedef enum logic [0:0] {
      MRD_ST_RUN = 1'b0,
      MRD_ST_FLUSH = 1'b1
   } mrd_state_e;
endpackage
